/* rtl/rsf_reset_ctrl.sv */
// Purpose: Reset cause decode, status flags and register defaults
// Assumes: Reset requests from pins are asynchronous and are synchronised here
// Notes: RESET_N is the power-on reset; AXI4-Lite reaches the registers
//
// Overview of operation
// - Halt watchdog reset: clear PC, SP; set timeout
// - Flags held; power-on clears both
// - Supply drop in run keeps both flags
// - Run watchdog reset sets timeout, keeps power-down
// - Halt watchdog reset sets both flags
// - Power-on disables all interrupt enables
// - Power-on clears watchdog, which starts counting
// - Power-on switches timers off
// - Power-on: ports inputs, four analog pins
// - Power-on points stack pointer at top
// - Cold resets load the eight peripheral register defaults; IRQ mask and status kept
// - Halt watchdog reset keeps other registers
// - Pin select restored except warm reset
// - Supply drop in run sets its flag; software or power-on clears
`include "rsf_regs.svh"
module rsf_reset_ctrl
  import rsf_pkg::*;
#(
  parameter int PC_WIDTH = 13,
  parameter int SP_WIDTH = 3
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic SUPPLY_DROP_RESET,
  input wire logic EXTERNAL_RESET_PIN_N,
  input wire logic WATCHDOG_OVERFLOW,
  input wire logic HALT_MODE,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [PC_WIDTH-1:0] PC_LOAD,
  output logic PC_LOAD_STB,
  output logic [SP_WIDTH-1:0] STACK_PTR_LOAD,
  output logic WATCHDOG_CLEAR,
  output logic [7:0] PORT_A_DATA,
  output logic [7:0] PORT_A_DIRECTION,
  output logic [7:0] PORT_A_PULLUP,
  output logic [7:0] RESET_PIN_SELECT,
  output logic [7:0] WATCHDOG_CONTROL,
  output logic [7:0] INT_ENABLE,
  output logic [7:0] TIMER_CTRL,
  output logic [7:0] PIN_SHARE,
  output logic WATCHDOG_TIMEOUT_FLAG,
  output logic POWER_DOWN_FLAG,
  output logic LOW_VOLTAGE_RESET_FLAG,
  output logic IRQ
);
  logic [2:0] pin_sync;
  logic drop_s;
  logic pin_s;
  logic wdog_s;
  logic drop_prev_q, drop_prev_d;
  logic pin_prev_q, pin_prev_d;
  logic wdog_prev_q, wdog_prev_d;
  logic ev_drop, ev_pin, ev_wdog;
  rsf_cause_t cause_q, cause_d;
  rsf_mode_t mode_q, mode_d;
  logic to_q, to_d, pdf_q, pdf_d, low_voltage_reset_flag_q, low_voltage_reset_flag_d;
  logic [7:0] pa_q, pa_d, pac_q, pac_d, port_a_pullup_q, port_a_pullup_d, psel_q, psel_d;
  logic [7:0] wdc_q, wdc_d, inten_q, inten_d, tmr_q, tmr_d, pshr_q, pshr_d;
  logic pc_stb_q, pc_stb_d, wdclr_q, wdclr_d;
  logic [4:0] ist_q, ist_d, imask_q, imask_d;
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d, ws_q, ws_d;
  logic [1:0] last_q, last_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic cold, warm, wr_go, wr_hit;
  logic [7:0] wb;
  logic [31:0] rmux;
  logic rhit;

  rsf_sync #(.WIDTH(3)) u_sync (
    .clk(CLK_SYS),
    .reset_n(RESET_N),
    .din({SUPPLY_DROP_RESET, ~EXTERNAL_RESET_PIN_N, WATCHDOG_OVERFLOW}),
    .dout(pin_sync)
  );
  assign {drop_s, pin_s, wdog_s} = pin_sync;

  // Rising edges only; a held request acts once
  always_comb begin
    drop_prev_d = drop_s;
    pin_prev_d = pin_s;
    wdog_prev_d = wdog_s;
    ev_drop = drop_s && !drop_prev_q;
    ev_pin = pin_s && !pin_prev_q;
    ev_wdog = wdog_s && !wdog_prev_q;
  end

  // Latch cause and mode at the request; drop is disabled in halt
  always_comb begin
    cause_d = RSF_NONE;
    mode_d = HALT_MODE ? RSF_HALT : RSF_RUN;
    if (ev_drop && !HALT_MODE) cause_d = RSF_DROP;
    else if (ev_pin) cause_d = RSF_PIN;
    else if (ev_wdog) cause_d = RSF_WDOG;
  end

  always_comb begin
    cold = (cause_q == RSF_DROP) || (cause_q == RSF_PIN) ||
      (cause_q == RSF_WDOG && mode_q == RSF_RUN);
    warm = (cause_q == RSF_WDOG) && (mode_q == RSF_HALT);
  end

  // Register write decode
  always_comb begin
    wr_go = aw_q && w_q && !bv_q;
    wb = wd_q[7:0];
    wr_hit = 1'b1;
    unique case (awa_q)
      `RSF_OFF_STATUS, `RSF_OFF_FLAGS, `RSF_OFF_CTRL, `RSF_OFF_PORTA,
      `RSF_OFF_PORTA_DIR, `RSF_OFF_PULLUP, `RSF_OFF_PIN_SEL,
      `RSF_OFF_WDOG_CTRL, `RSF_OFF_INT_EN, `RSF_OFF_TIMER,
      `RSF_OFF_PIN_SHARE, `RSF_OFF_IRQ_STAT, `RSF_OFF_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    to_d = to_q;
    pdf_d = pdf_q;
    low_voltage_reset_flag_d = low_voltage_reset_flag_q;
    pa_d = pa_q;
    pac_d = pac_q;
    port_a_pullup_d = port_a_pullup_q;
    psel_d = psel_q;
    wdc_d = wdc_q;
    inten_d = inten_q;
    tmr_d = tmr_q;
    pshr_d = pshr_q;
    imask_d = imask_q;
    ist_d = ist_q;
    last_d = last_q;
    pc_stb_d = cold || warm;
    wdclr_d = cold || warm;
    if (wr_go && ws_q) begin
      unique case (awa_q)
        `RSF_OFF_FLAGS: if (!wb[`RSF_BIT_SUPPLY_DROP]) low_voltage_reset_flag_d = 1'b0;
        `RSF_OFF_PORTA: pa_d = wb;
        `RSF_OFF_PORTA_DIR: pac_d = wb;
        `RSF_OFF_PULLUP: port_a_pullup_d = wb;
        `RSF_OFF_PIN_SEL: psel_d = wb;
        `RSF_OFF_WDOG_CTRL: wdc_d = wb;
        `RSF_OFF_INT_EN: inten_d = wb;
        `RSF_OFF_TIMER: tmr_d = wb;
        `RSF_OFF_PIN_SHARE: pshr_d = wb;
        `RSF_OFF_IRQ_STAT: ist_d = ist_q & ~wb[4:0];
        `RSF_OFF_IRQ_MASK: imask_d = wb[4:0];
        default: ;
      endcase
    end
    if (cold) begin
      pa_d = `RSF_RST_PORTA;
      pac_d = `RSF_RST_PORTA_DIR;
      port_a_pullup_d = `RSF_RST_PULLUP;
      psel_d = `RSF_RST_PIN_SEL;
      wdc_d = `RSF_RST_WDOG_CTRL;
      inten_d = `RSF_RST_INT_EN;
      tmr_d = `RSF_RST_TIMER;
      pshr_d = `RSF_PIN_SHARE_ANALOG;
    end
    if (cause_q == RSF_WDOG) to_d = 1'b1;
    if (warm) pdf_d = 1'b1;
    // Drop in run: timeout and power-down flags untouched
    if (cause_q == RSF_DROP) low_voltage_reset_flag_d = 1'b1;
    // Events set sticky bits; set wins over a clear
    if (cause_q == RSF_DROP) ist_d[`RSF_EV_DROP] = 1'b1;
    if (cause_q == RSF_PIN) ist_d[`RSF_EV_PIN] = 1'b1;
    if (cold && cause_q == RSF_WDOG) ist_d[`RSF_EV_WDOG] = 1'b1;
    if (warm) ist_d[`RSF_EV_WARM] = 1'b1;
    // Held until the next event so software can read it later
    if (cause_q != RSF_NONE) last_d = {mode_q == RSF_HALT, cause_q == RSF_WDOG};
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      drop_prev_q <= 1'b0;
      pin_prev_q <= 1'b0;
      wdog_prev_q <= 1'b0;
      cause_q <= RSF_NONE;
      mode_q <= RSF_RUN;
      to_q <= 1'b0;
      pdf_q <= 1'b0;
      low_voltage_reset_flag_q <= 1'b0;
      pa_q <= `RSF_RST_PORTA;
      pac_q <= `RSF_RST_PORTA_DIR;
      port_a_pullup_q <= `RSF_RST_PULLUP;
      psel_q <= `RSF_RST_PIN_SEL;
      wdc_q <= `RSF_RST_WDOG_CTRL;
      inten_q <= `RSF_RST_INT_EN;
      tmr_q <= `RSF_RST_TIMER;
      pshr_q <= `RSF_PIN_SHARE_ANALOG;
      pc_stb_q <= 1'b1;
      wdclr_q <= 1'b1;
      ist_q <= 5'(1 << `RSF_EV_POR);
      imask_q <= 5'h00;
      last_q <= 2'h0;
    end else begin
      drop_prev_q <= drop_prev_d;
      pin_prev_q <= pin_prev_d;
      wdog_prev_q <= wdog_prev_d;
      cause_q <= cause_d;
      mode_q <= mode_d;
      to_q <= to_d;
      pdf_q <= pdf_d;
      low_voltage_reset_flag_q <= low_voltage_reset_flag_d;
      pa_q <= pa_d;
      pac_q <= pac_d;
      port_a_pullup_q <= port_a_pullup_d;
      psel_q <= psel_d;
      wdc_q <= wdc_d;
      inten_q <= inten_d;
      tmr_q <= tmr_d;
      pshr_q <= pshr_d;
      pc_stb_q <= pc_stb_d;
      wdclr_q <= wdclr_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      last_q <= last_d;
    end
  end

  // AXI4-Lite slave: one write, one read at a time
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    bresp_d = bresp_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_d = 1'b1;
      awa_d = S_AXI_AWADDR[7:0];
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_d = 1'b1;
      wd_d = S_AXI_WDATA;
      // Strobe only qualifies data while WVALID stands
      ws_d = S_AXI_WSTRB[0];
    end
    if (wr_go) begin
      bv_d = 1'b1;
      bresp_d = wr_hit ? 2'h0 : 2'h2;
    end
    if (bv_q && S_AXI_BREADY) begin
      bv_d = 1'b0;
      aw_d = 1'b0;
      w_d = 1'b0;
    end
  end

  always_comb begin
    rhit = 1'b1;
    rmux = 32'h0000_0000;
    unique case (S_AXI_ARADDR[7:0])
      `RSF_OFF_STATUS: rmux[1:0] = {pdf_q, to_q};
      `RSF_OFF_FLAGS: rmux[`RSF_BIT_SUPPLY_DROP] = low_voltage_reset_flag_q;
      `RSF_OFF_CTRL: rmux[1:0] = last_q;
      `RSF_OFF_PORTA: rmux[7:0] = pa_q;
      `RSF_OFF_PORTA_DIR: rmux[7:0] = pac_q;
      `RSF_OFF_PULLUP: rmux[7:0] = port_a_pullup_q;
      `RSF_OFF_PIN_SEL: rmux[7:0] = psel_q;
      `RSF_OFF_WDOG_CTRL: rmux[7:0] = wdc_q;
      `RSF_OFF_INT_EN: rmux[7:0] = inten_q;
      `RSF_OFF_TIMER: rmux[7:0] = tmr_q;
      `RSF_OFF_PIN_SHARE: rmux[7:0] = pshr_q;
      `RSF_OFF_IRQ_STAT: rmux[4:0] = ist_q;
      `RSF_OFF_IRQ_MASK: rmux[4:0] = imask_q;
      default: rhit = 1'b0;
    endcase
    rv_d = rv_q;
    rd_d = rd_q;
    rresp_d = rresp_q;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rv_d = 1'b1;
      rd_d = rmux;
      rresp_d = rhit ? 2'h0 : 2'h2;
    end else if (rv_q && S_AXI_RREADY) begin
      rv_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 1'b0;
      bv_q <= 1'b0;
      bresp_q <= 2'h0;
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      bresp_q <= bresp_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rresp_q <= rresp_d;
    end
  end

  assign S_AXI_AWREADY = !aw_q;
  assign S_AXI_WREADY = !w_q;
  assign S_AXI_BVALID = bv_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = !rv_q;
  assign S_AXI_RVALID = rv_q;
  assign S_AXI_RDATA = rd_q;
  assign S_AXI_RRESP = rresp_q;
  assign PC_LOAD = PC_WIDTH'(`RSF_PC_RESET);
  assign PC_LOAD_STB = pc_stb_q;
  assign STACK_PTR_LOAD = SP_WIDTH'(`RSF_SP_TOP);
  assign WATCHDOG_CLEAR = wdclr_q;
  assign PORT_A_DATA = pa_q;
  assign PORT_A_DIRECTION = pac_q;
  assign PORT_A_PULLUP = port_a_pullup_q;
  assign RESET_PIN_SELECT = psel_q;
  assign WATCHDOG_CONTROL = wdc_q;
  assign INT_ENABLE = inten_q;
  assign TIMER_CTRL = tmr_q;
  assign PIN_SHARE = pshr_q;
  assign WATCHDOG_TIMEOUT_FLAG = to_q;
  assign POWER_DOWN_FLAG = pdf_q;
  assign LOW_VOLTAGE_RESET_FLAG = low_voltage_reset_flag_q;
  assign IRQ = |(ist_q & imask_q);

  warm_keep_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    warm |=> $stable(pa_q) && $stable(psel_q) && $stable(inten_q) && pc_stb_q)
    else $error("warm reset changed a register");
  halt_flags_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    warm |=> to_q && pdf_q)
    else $error("halt watchdog flags wrong");
  run_wdog_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (cause_q == RSF_WDOG && mode_q == RSF_RUN) |=> to_q && $stable(pdf_q))
    else $error("run watchdog flags wrong");
  drop_keep_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (cause_q == RSF_DROP) |=> $stable(to_q) && $stable(pdf_q) && low_voltage_reset_flag_q)
    else $error("supply drop touched flags");
  por_clear_a: assert property (@(posedge CLK_SYS)
    $rose(RESET_N) |-> !to_q && !pdf_q && inten_q == `RSF_RST_INT_EN && tmr_q == `RSF_RST_TIMER)
    else $error("power-on state wrong");
  cold_dflt_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    cold |=> pa_q == `RSF_RST_PORTA && wdc_q == `RSF_RST_WDOG_CTRL && psel_q == `RSF_RST_PIN_SEL)
    else $error("cold defaults wrong");
  pin_event_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (ev_pin && !(ev_drop && !HALT_MODE)) |=> ##1 pc_stb_q && wdclr_q)
    else $error("pin reset not applied in two cycles");
  low_voltage_reset_flag_set_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    $rose(low_voltage_reset_flag_q) |-> $past(cause_q) == RSF_DROP)
    else $error("low voltage flag set without a drop");
  warm_c: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) warm);
  cold_wdog_c: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
    cold && cause_q == RSF_WDOG);
  drop_c: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) cause_q == RSF_DROP);
  irq_c: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) $rose(IRQ));
endmodule : rsf_reset_ctrl

/* rtl/rsf_regs.svh */
// Purpose: Constants of the reset state and flag logic
// Assumes: Byte-wide peripheral registers, 32-bit AXI4-Lite data
// Notes: Offsets are byte addresses of aligned words
`ifndef RSF_REGS_SVH
`define RSF_REGS_SVH
`define RSF_OFF_STATUS 8'h00
`define RSF_OFF_FLAGS 8'h04
`define RSF_OFF_CTRL 8'h08
`define RSF_OFF_PORTA 8'h0C
`define RSF_OFF_PORTA_DIR 8'h10
`define RSF_OFF_PULLUP 8'h14
`define RSF_OFF_PIN_SEL 8'h18
`define RSF_OFF_WDOG_CTRL 8'h1C
`define RSF_OFF_INT_EN 8'h20
`define RSF_OFF_TIMER 8'h24
`define RSF_OFF_PIN_SHARE 8'h28
`define RSF_OFF_IRQ_STAT 8'h2C
`define RSF_OFF_IRQ_MASK 8'h30
`define RSF_RST_PORTA 8'hFF
`define RSF_RST_PORTA_DIR 8'hFF
`define RSF_RST_PULLUP 8'h00
`define RSF_RST_PIN_SEL 8'h55
`define RSF_RST_WDOG_CTRL 8'h53
`define RSF_RST_INT_EN 8'h00
`define RSF_RST_TIMER 8'h00
`define RSF_RST_PIN_SHARE 8'h00
`define RSF_PIN_SHARE_ANALOG 8'h1E
`define RSF_SP_TOP 3'h0
`define RSF_PC_RESET 13'h0000
`define RSF_ALL_ONE 3'h7
`define RSF_BIT_TIMEOUT 0
`define RSF_BIT_POWER_DOWN 1
`define RSF_BIT_SUPPLY_DROP 2
`define RSF_EV_POR 0
`define RSF_EV_DROP 1
`define RSF_EV_PIN 2
`define RSF_EV_WDOG 3
`define RSF_EV_WARM 4
`define RSF_SYNC_RST 2'h3
`endif

/* rtl/rsf_pkg.sv */
// Purpose: Types of the reset state and flag logic
// Assumes: Used by rsf_reset_ctrl
// Notes: One-hot codes written out
package rsf_pkg;
  typedef enum logic [4:0] {
    RSF_NONE = 5'h01,
    RSF_POR = 5'h02,
    RSF_DROP = 5'h04,
    RSF_PIN = 5'h08,
    RSF_WDOG = 5'h10
  } rsf_cause_t;
  typedef enum logic [1:0] {
    RSF_RUN = 2'h1,
    RSF_HALT = 2'h2
  } rsf_mode_t;
endpackage : rsf_pkg

/* rtl/rsf_sync.sv */
// Purpose: Two-flop synchroniser for a bank of pin levels
// Assumes: Destination clock is CLK_SYS
// Notes: First stage is read only by the second
`include "rsf_regs.svh"
module rsf_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign dout = sync_q;
endmodule : rsf_sync

/* bench/rsf_core_model.sv */
// Purpose: Core-side stand-in that takes the reset loads
// Assumes: Load strobe is a one-cycle pulse on the system clock
// Notes: Watchdog count runs whenever it is not held clear
module rsf_core_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic load_stb,
  input wire logic [12:0] pc_in,
  input wire logic [2:0] sp_in,
  input wire logic wd_clear,
  output logic [12:0] last_pc_q,
  output logic [2:0] last_sp_q,
  output logic [7:0] loads_q,
  output logic [15:0] wd_cnt_q
);
  always_ff @(posedge clk) begin
    if (load_stb) begin
      last_pc_q <= pc_in;
      last_sp_q <= sp_in;
    end
    // Counts loads so a held request that reloads twice shows up
    loads_q <= !reset_n ? 8'h00 : loads_q + {7'h00, load_stb};
    wd_cnt_q <= wd_clear ? 16'h0000 : wd_cnt_q + 16'h0001;
  end
endmodule : rsf_core_model

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the reset cause and flag logic
// Assumes: Reset requests are slow levels held for a few cycles
// Notes: Reads are scored by a monitor against a queue of notes
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("[ERR] %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 0, RESET_N = 0, SUPPLY_DROP_RESET = 0, EXTERNAL_RESET_PIN_N = 1;
  logic WATCHDOG_OVERFLOW = 0, HALT_MODE = 0;
  logic [31:0] S_AXI_AWADDR = 0, S_AXI_WDATA = 0, S_AXI_ARADDR = 0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
  logic S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, PC_LOAD_STB, WATCHDOG_CLEAR, IRQ;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [12:0] PC_LOAD, last_pc;
  logic [2:0] STACK_PTR_LOAD, last_sp;
  logic [7:0] PORT_A_DATA, PORT_A_DIRECTION, PORT_A_PULLUP, RESET_PIN_SELECT;
  logic [7:0] WATCHDOG_CONTROL, INT_ENABLE, TIMER_CTRL, PIN_SHARE, loads;
  logic WATCHDOG_TIMEOUT_FLAG, POWER_DOWN_FLAG, LOW_VOLTAGE_RESET_FLAG;
  logic [15:0] wd_cnt;
  logic [33:0] exp_q[$];
  logic [33:0] e_mon;
  logic [7:0] cur[8];
  logic [7:0] dflt[8] = '{8'hFF, 8'hFF, 8'h00, 8'h55, 8'h53, 8'h00, 8'h00, 8'h1E};
  int seed = 32'h42bc970b;
  int bad_count = 0;
  int n_compared = 0;

  rsf_reset_ctrl i_dut (.CLK_SYS, .RESET_N, .SUPPLY_DROP_RESET, .EXTERNAL_RESET_PIN_N,
    .WATCHDOG_OVERFLOW, .HALT_MODE, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .PC_LOAD, .PC_LOAD_STB, .STACK_PTR_LOAD,
    .WATCHDOG_CLEAR, .PORT_A_DATA, .PORT_A_DIRECTION, .PORT_A_PULLUP, .RESET_PIN_SELECT,
    .WATCHDOG_CONTROL, .INT_ENABLE, .TIMER_CTRL, .PIN_SHARE, .WATCHDOG_TIMEOUT_FLAG,
    .POWER_DOWN_FLAG, .LOW_VOLTAGE_RESET_FLAG, .IRQ);
  rsf_core_model i_core (.clk(CLK_SYS), .reset_n(RESET_N), .load_stb(PC_LOAD_STB),
    .pc_in(PC_LOAD), .sp_in(STACK_PTR_LOAD), .wd_clear(WATCHDOG_CLEAR),
    .last_pc_q(last_pc), .last_sp_q(last_sp), .loads_q(loads), .wd_cnt_q(wd_cnt));

  initial forever #50 CLK_SYS = ~CLK_SYS;

  always @(posedge CLK_SYS) begin
    if (S_AXI_RVALID && S_AXI_RREADY && exp_q.size() > 0) begin
      e_mon = exp_q.pop_front();
      `CHK("read", e_mon, {S_AXI_RRESP, S_AXI_RDATA})
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rsp);
    logic aw_t;
    logic w_t;
    aw_t = 0;
    w_t = 0;
    S_AXI_AWADDR <= {24'h0, a};
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!(aw_t && w_t)) begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY && !aw_t) begin
        aw_t = 1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (S_AXI_WREADY && !w_t) begin
        w_t = 1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    do @(posedge CLK_SYS); while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
    `CHK("bresp", rsp, S_AXI_BRESP)
    @(posedge CLK_SYS);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] rsp);
    exp_q.push_back({rsp, e});
    S_AXI_ARADDR <= {24'h0, a};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge CLK_SYS); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLK_SYS); while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
    @(posedge CLK_SYS);
  endtask : rd

  // Kinds: 0 supply drop, 1 reset pin, else watchdog
  task automatic ev(input int k, input logic [7:0] inc);
    logic [7:0] n0;
    n0 = loads;
    @(posedge CLK_SYS);
    if (k == 0) SUPPLY_DROP_RESET <= 1'b1;
    else if (k == 1) EXTERNAL_RESET_PIN_N <= 1'b0;
    else WATCHDOG_OVERFLOW <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    SUPPLY_DROP_RESET <= 1'b0;
    EXTERNAL_RESET_PIN_N <= 1'b1;
    WATCHDOG_OVERFLOW <= 1'b0;
    repeat (10) @(posedge CLK_SYS);
    `CHK("loads", n0 + inc, loads)
  endtask : ev

  task automatic scramble();
    for (int i = 0; i < 8; i++) begin
      cur[i] = 8'($random(seed));
      wr(8'h0C + 8'(4 * i), cur[i], 2'h0);
    end
  endtask : scramble

  task automatic regs(input logic warm);
    for (int i = 0; i < 8; i++) begin
      rd(8'h0C + 8'(4 * i), {24'h0, warm ? cur[i] : dflt[i]}, 2'h0);
    end
  endtask : regs

  // Level output, so look at it away from the launching edge
  task automatic irq_is(input logic e);
    @(negedge CLK_SYS);
    `CHK("irq", e, IRQ)
    @(posedge CLK_SYS);
  endtask : irq_is

  task automatic conclude();
    `CHK("pending", 0, exp_q.size())
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (30000) @(posedge CLK_SYS);
    bad_count++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    @(posedge CLK_SYS);
    regs(0);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h2C, 32'h1, 2'h0);
    irq_is(1'b0);
    wr(8'h30, 8'h1F, 2'h0);
    irq_is(1'b1);
    wr(8'h2C, 8'h01, 2'h0);
    irq_is(1'b0);
    wr(8'h3C, 8'h01, 2'h2);
    rd(8'h3C, 32'h0, 2'h2);
    scramble();
    ev(2, 1);
    rd(8'h00, 32'h1, 2'h0);
    rd(8'h08, 32'h1, 2'h0);
    regs(0);
    scramble();
    // Drop with the timeout flag already set, so keeping it is visible
    ev(0, 1);
    rd(8'h00, 32'h1, 2'h0);
    rd(8'h04, 32'h4, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    irq_is(1'b1);
    regs(0);
    wr(8'h04, 8'h04, 2'h0);
    rd(8'h04, 32'h4, 2'h0);
    wr(8'h04, 8'h00, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    scramble();
    ev(1, 1);
    rd(8'h00, 32'h1, 2'h0);
    regs(0);
    scramble();
    HALT_MODE <= 1'b1;
    ev(2, 1);
    `CHK("wdog", 1'b1, wd_cnt != 16'h0000 && wd_cnt < 16'h001E)
    `CHK("pc", 13'h0, last_pc)
    `CHK("sp", 3'h0, last_sp)
    rd(8'h00, 32'h3, 2'h0);
    rd(8'h08, 32'h3, 2'h0);
    regs(1);
    ev(0, 0);
    rd(8'h04, 32'h0, 2'h0);
    HALT_MODE <= 1'b0;
    // Power-down flag now set: run resets must keep it
    ev(2, 1);
    rd(8'h00, 32'h3, 2'h0);
    ev(0, 1);
    rd(8'h00, 32'h3, 2'h0);
    rd(8'h04, 32'h4, 2'h0);
    rd(8'h2C, 32'h1E, 2'h0);
    wr(8'h2C, 8'h1E, 2'h0);
    rd(8'h2C, 32'h0, 2'h0);
    RESET_N <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    @(posedge CLK_SYS);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h2C, 32'h1, 2'h0);
    regs(0);
    repeat (4) @(posedge CLK_SYS);
    conclude();
  end
endmodule : tb_top
